// ===== blm_addr_plan.sv
`timescale 1ns/1ps
module blm_addr_plan (
  // Decode and address plan
  blm_plan_if.planner plan
);

  // Condition test against N Z C V; code 4'hf never passes
  function automatic logic blm_cond_pass(input logic [3:0] c, input logic [3:0] f);
    logic n;
    logic z;
    logic cy;
    logic v;
    logic r;
    n = f[3];
    z = f[2];
    cy = f[1];
    v = f[0];
    r = 1'b0;
    unique case (c)
      4'h0: r = z;
      4'h1: r = !z;
      4'h2: r = cy;
      4'h3: r = !cy;
      4'h4: r = n;
      4'h5: r = !n;
      4'h6: r = v;
      4'h7: r = !v;
      4'h8: r = cy && !z;
      4'h9: r = !cy || z;
      4'ha: r = (n == v);
      4'hb: r = (n != v);
      4'hc: r = !z && (n == v);
      4'hd: r = z || (n != v);
      4'he: r = 1'b1;
      4'hf: r = 1'b0;
    endcase
    return r;
  endfunction : blm_cond_pass

  logic [4:0] count;
  logic [31:0] span;
  logic [31:0] base;

  // Population count of the mask sets the size of the block
  always_comb begin
    count = 5'h00;
    for (int i = 0; i < 16; i++) begin
      count = count + {4'h0, plan.instr[i]};
    end
    span = {25'h0000000, count, 2'b00};
    base = plan.base_value;
  end

  // Form select and start, end and writeback addresses
  always_comb begin
    plan.cond_ok = blm_cond_pass(plan.instr[31:blm_pkg::BLM_COND_LSB], plan.flags);
    if (!plan.instr[blm_pkg::BLM_BANK_BIT]) begin
      plan.form = blm_pkg::BLM_FORM_NORMAL;
    end else if (plan.instr[blm_pkg::BLM_PC_MASK_BIT]) begin
      plan.form = blm_pkg::BLM_FORM_EXRET;
    end else begin
      plan.form = blm_pkg::BLM_FORM_USER;
    end
    // Increment/decrement, before/after
    unique case ({plan.instr[blm_pkg::BLM_PRE_BIT], plan.instr[blm_pkg::BLM_UP_BIT]})
      2'b01: begin
        plan.start_addr = base;
        plan.end_addr = base + span - blm_pkg::BLM_WORD_BYTES;
        plan.wb_addr = base + span;
      end
      2'b11: begin
        plan.start_addr = base + blm_pkg::BLM_WORD_BYTES;
        plan.end_addr = base + span;
        plan.wb_addr = base + span;
      end
      2'b00: begin
        plan.start_addr = base - span + blm_pkg::BLM_WORD_BYTES;
        plan.end_addr = base;
        plan.wb_addr = base - span;
      end
      2'b10: begin
        plan.start_addr = base - span;
        plan.end_addr = base - blm_pkg::BLM_WORD_BYTES;
        plan.wb_addr = base - span;
      end
    endcase
  end

endmodule : blm_addr_plan

// ===== blm_block_load.sv
`timescale 1ns/1ps
module blm_block_load (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction issue
  input wire logic start,
  input wire logic [31:0] instr,
  input wire logic [3:0] flags,
  input wire logic [31:0] base_value,
  input wire logic [31:0] saved_status_word,
  input wire logic align_check_en,
  // Memory request and response
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_abort,
  // Register file write
  output logic rf_we,
  output logic [3:0] rf_idx,
  output logic rf_user_bank,
  output logic [31:0] rf_data,
  // Program counter, status word and base writeback
  output logic pc_we,
  output logic [31:0] program_counter_reg,
  output logic status_we,
  output logic [31:0] current_status_word,
  output logic base_we,
  output logic [3:0] base_reg_field,
  output logic [31:0] base_data,
  // Completion
  output logic busy,
  output logic done,
  output logic data_abort,
  output logic align_fault
);

  typedef struct packed {
    blm_pkg::blm_state_t state;
    blm_pkg::blm_form_t form;
    logic [15:0] mask;
    logic wb;
    logic skip;
    logic aborted;
    logic pc_pend;
    logic [31:0] addr;
    logic [31:0] last_addr;
    logic [31:0] end_addr;
    logic [31:0] wb_addr;
    logic mem_req;
    logic [31:0] mem_addr;
    logic rf_we;
    logic [3:0] rf_idx;
    logic rf_user_bank;
    logic [31:0] rf_data;
    logic pc_we;
    logic [31:0] pc_data;
    logic status_we;
    logic [31:0] status_data;
    logic base_we;
    logic [3:0] base_idx;
    logic [31:0] base_data;
    logic busy;
    logic done;
    logic data_abort;
    logic align_fault;
  } blm_core_t;

  // Lowest set bit of a register mask
  function automatic logic [3:0] blm_lowest(input logic [15:0] m);
    logic [3:0] r;
    r = blm_pkg::BLM_RST_IDX;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : blm_lowest

  blm_core_t s_reg;
  blm_core_t s_next;
  logic [3:0] pick;
  logic [15:0] left;
  blm_plan_if plan ();

  assign plan.instr = instr;
  assign plan.flags = flags;
  assign plan.base_value = base_value;

  blm_addr_plan u_plan (
    .plan(plan)
  );

  assign pick = blm_lowest(s_reg.mask);
  assign left = s_reg.mask & ~(16'h0001 << pick);

  // Sequencer; pulses default low each cycle
  always_comb begin
    s_next = s_reg;
    s_next.mem_req = 1'b0;
    s_next.rf_we = 1'b0;
    s_next.pc_we = 1'b0;
    s_next.status_we = 1'b0;
    s_next.base_we = 1'b0;
    s_next.done = 1'b0;
    s_next.data_abort = 1'b0;
    s_next.align_fault = 1'b0;
    unique case (s_reg.state)
      blm_pkg::BLM_ST_IDLE: begin
        if (start) begin
          s_next.busy = 1'b1;
          s_next.form = plan.form;
          s_next.mask = instr[15:0];
          s_next.wb = instr[blm_pkg::BLM_WB_BIT];
          s_next.base_idx = instr[19:blm_pkg::BLM_BASE_LSB];
          s_next.addr = plan.start_addr;
          s_next.last_addr = plan.start_addr;
          s_next.end_addr = plan.end_addr;
          s_next.wb_addr = plan.wb_addr;
          s_next.status_data = saved_status_word;
          s_next.aborted = 1'b0;
          s_next.pc_pend = 1'b0;
          s_next.skip = 1'b0;
          if (!plan.cond_ok) begin
            s_next.skip = 1'b1;
            s_next.state = blm_pkg::BLM_ST_FINISH;
          end else if (align_check_en && plan.start_addr[1:0] != blm_pkg::BLM_ALIGNED) begin
            s_next.skip = 1'b1;
            s_next.align_fault = 1'b1;
            s_next.state = blm_pkg::BLM_ST_FINISH;
          end else if (instr[15:0] == blm_pkg::BLM_RST_MASK) begin
            // Empty mask is illegal; retire it as a no-op
            s_next.skip = 1'b1;
            s_next.state = blm_pkg::BLM_ST_FINISH;
          end else begin
            s_next.state = blm_pkg::BLM_ST_ISSUE;
          end
        end
      end
      blm_pkg::BLM_ST_ISSUE: begin
        s_next.mem_req = 1'b1;
        s_next.mem_addr = {s_reg.addr[31:2], 2'b00};
        s_next.state = blm_pkg::BLM_ST_WAIT;
      end
      blm_pkg::BLM_ST_WAIT: begin
        if (mem_rvalid) begin
          if (mem_abort) begin
            // Stop at once; commit stage will hold PC, base and status
            s_next.aborted = 1'b1;
            s_next.data_abort = 1'b1;
            s_next.state = blm_pkg::BLM_ST_FINISH;
          end else begin
            if (pick == blm_pkg::BLM_PC_IDX && s_reg.form != blm_pkg::BLM_FORM_USER) begin
              // PC is held back until no abort can follow
              s_next.pc_pend = 1'b1;
              s_next.pc_data = mem_rdata;
            end else begin
              s_next.rf_we = 1'b1;
              s_next.rf_idx = pick;
              s_next.rf_user_bank = (s_reg.form == blm_pkg::BLM_FORM_USER);
              s_next.rf_data = mem_rdata;
            end
            s_next.mask = left;
            s_next.last_addr = s_reg.addr;
            s_next.addr = s_reg.addr + blm_pkg::BLM_WORD_BYTES;
            s_next.state = (left == blm_pkg::BLM_RST_MASK) ? blm_pkg::BLM_ST_FINISH
                                                           : blm_pkg::BLM_ST_ISSUE;
          end
        end
      end
      blm_pkg::BLM_ST_FINISH: begin
        s_next.done = 1'b1;
        s_next.busy = 1'b0;
        s_next.state = blm_pkg::BLM_ST_IDLE;
        // Aborted or skipped instructions commit nothing
        if (!s_reg.skip && !s_reg.aborted) begin
          s_next.pc_we = s_reg.pc_pend;
          s_next.status_we = (s_reg.form == blm_pkg::BLM_FORM_EXRET);
          if (s_reg.wb && s_reg.form != blm_pkg::BLM_FORM_USER) begin
            s_next.base_we = 1'b1;
            s_next.base_data = s_reg.wb_addr;
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '{
        state: blm_pkg::BLM_ST_IDLE, form: blm_pkg::BLM_FORM_NORMAL,
        mask: blm_pkg::BLM_RST_MASK, rf_idx: blm_pkg::BLM_RST_IDX,
        base_idx: blm_pkg::BLM_RST_IDX, addr: blm_pkg::BLM_RST_WORD,
        last_addr: blm_pkg::BLM_RST_WORD, end_addr: blm_pkg::BLM_RST_WORD,
        wb_addr: blm_pkg::BLM_RST_WORD, mem_addr: blm_pkg::BLM_RST_WORD,
        rf_data: blm_pkg::BLM_RST_WORD, pc_data: blm_pkg::BLM_RST_WORD,
        status_data: blm_pkg::BLM_RST_WORD, base_data: blm_pkg::BLM_RST_WORD,
        default: 1'b0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from the state register
  assign mem_req = s_reg.mem_req;
  assign mem_addr = s_reg.mem_addr;
  assign rf_we = s_reg.rf_we;
  assign rf_idx = s_reg.rf_idx;
  assign rf_user_bank = s_reg.rf_user_bank;
  assign rf_data = s_reg.rf_data;
  assign pc_we = s_reg.pc_we;
  assign program_counter_reg = s_reg.pc_data;
  assign status_we = s_reg.status_we;
  assign current_status_word = s_reg.status_data;
  assign base_we = s_reg.base_we;
  assign base_reg_field = s_reg.base_idx;
  assign base_data = s_reg.base_data;
  assign busy = s_reg.busy;
  assign done = s_reg.done;
  assign data_abort = s_reg.data_abort;
  assign align_fault = s_reg.align_fault;

  // Helper: address of previous request inside one instruction
  logic have_prev;
  logic [31:0] prev_addr;
  always_ff @(posedge clk) begin
    if (rst || !s_reg.busy) begin
      have_prev <= 1'b0;
      prev_addr <= 32'h0000_0000;
    end else if (s_reg.mem_req) begin
      have_prev <= 1'b1;
      prev_addr <= s_reg.mem_addr;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic take;
  assign take = start && s_reg.state == blm_pkg::BLM_ST_IDLE;

  property p_cond_skip;
    take && !plan.cond_ok |-> ##1 !mem_req ##1 (done && !pc_we && !status_we && !base_we);
  endproperty
  a_cond_skip: assert property (p_cond_skip) else $error("failed condition still acted");

  property p_ascending;
    rf_we |-> rf_idx == blm_lowest($past(s_reg.mask));
  endproperty
  a_ascending: assert property (p_ascending) else $error("register order not ascending");

  property p_step;
    mem_req && have_prev |-> mem_addr == prev_addr + blm_pkg::BLM_WORD_BYTES;
  endproperty
  a_step: assert property (p_step) else $error("address did not step one word");

  property p_end_addr;
    s_reg.state == blm_pkg::BLM_ST_FINISH && !s_reg.skip && !s_reg.aborted
      |-> s_reg.last_addr == s_reg.end_addr;
  endproperty
  a_end_addr: assert property (p_end_addr) else $error("last address is not end address");

  property p_user_no_pc;
    rf_we && rf_user_bank |-> rf_idx != blm_pkg::BLM_PC_IDX && !pc_we;
  endproperty
  a_user_no_pc: assert property (p_user_no_pc) else $error("user-bank write hit PC");

  property p_abort_hold;
    data_abort |-> ##1 (done && !pc_we && !base_we && !status_we);
  endproperty
  a_abort_hold: assert property (p_abort_hold) else $error("abort committed PC or base");

  property p_status;
    status_we |-> done && pc_we
      && s_reg.form == blm_pkg::BLM_FORM_EXRET;
  endproperty
  a_status: assert property (p_status) else $error("status restore out of place");

  property p_wb;
    base_we |-> base_data == s_reg.wb_addr && s_reg.wb && s_reg.form != blm_pkg::BLM_FORM_USER;
  endproperty
  a_wb: assert property (p_wb) else $error("base writeback wrong");

  property p_align;
    mem_req |-> mem_addr[1:0] == blm_pkg::BLM_ALIGNED;
  endproperty
  a_align: assert property (p_align) else $error("request address not word aligned");

  property p_align_fault;
    take && plan.cond_ok && align_check_en && plan.start_addr[1:0] != blm_pkg::BLM_ALIGNED
      |-> ##1 (align_fault && !mem_req) ##1 (done && !rf_we && !base_we);
  endproperty
  a_align_fault: assert property (p_align_fault) else $error("alignment fault missed");

  c_pc_load: cover property (pc_we && !status_we);
  c_exret: cover property (pc_we && status_we);
  c_user: cover property (rf_we && rf_user_bank);
  c_abort: cover property (data_abort);

endmodule : blm_block_load

// ===== blm_mem_model.sv
`timescale 1ns/1ps
module blm_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Word read request
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  // Test controls
  input wire logic [3:0] lat,
  input wire logic abort_en,
  input wire logic [31:0] abort_addr,
  // Response
  output logic mem_rvalid,
  output logic [31:0] mem_rdata,
  output logic mem_abort
);
  logic pend_reg;
  logic [3:0] cnt_reg;
  logic [31:0] addr_reg;

  // Distinct word per address so every slot is traceable
  function automatic logic [31:0] word_at(input logic [31:0] a);
    return {a[15:0] ^ 16'hc3c3, a[15:0]};
  endfunction : word_at

  // One outstanding read; idle data toggles so a stale word never matches
  always @(posedge clk) begin
    mem_rvalid <= 1'b0;
    mem_abort <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      pend_reg <= 1'b0;
      mem_rdata <= 32'h5a5a_5a5a;
    end else begin
      if (pend_reg && cnt_reg <= 4'h1) begin
        mem_rvalid <= 1'b1;
        mem_rdata <= word_at(addr_reg);
        mem_abort <= abort_en && addr_reg == abort_addr;
        pend_reg <= 1'b0;
      end else if (pend_reg) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
      if (mem_req) begin
        pend_reg <= 1'b1;
        cnt_reg <= lat;
        addr_reg <= mem_addr;
      end
    end
  end
endmodule : blm_mem_model

// ===== blm_pkg.sv
package blm_pkg;

  // Instruction word layout
  localparam int unsigned BLM_COND_LSB = 28;
  localparam int unsigned BLM_PRE_BIT = 24;
  localparam int unsigned BLM_UP_BIT = 23;
  localparam int unsigned BLM_BANK_BIT = 22;
  localparam int unsigned BLM_WB_BIT = 21;
  localparam int unsigned BLM_BASE_LSB = 16;
  localparam int unsigned BLM_PC_MASK_BIT = 15;
  localparam logic [3:0] BLM_PC_IDX = 4'hf;

  // Word stepping and alignment
  localparam logic [31:0] BLM_WORD_BYTES = 32'h0000_0004;
  localparam logic [1:0] BLM_ALIGNED = 2'h0;

  // Values after reset
  localparam logic [31:0] BLM_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] BLM_RST_MASK = 16'h0000;
  localparam logic [3:0] BLM_RST_IDX = 4'h0;

  typedef enum logic [1:0] {
    BLM_FORM_NORMAL = 2'b00,
    BLM_FORM_USER = 2'b01,
    BLM_FORM_EXRET = 2'b10
  } blm_form_t;

  typedef enum logic [1:0] {
    BLM_ST_IDLE = 2'b00,
    BLM_ST_ISSUE = 2'b01,
    BLM_ST_WAIT = 2'b10,
    BLM_ST_FINISH = 2'b11
  } blm_state_t;

endpackage : blm_pkg

// ===== blm_plan_if.sv
`timescale 1ns/1ps
interface blm_plan_if;
  logic [31:0] instr;
  logic [3:0] flags;
  logic [31:0] base_value;
  logic cond_ok;
  blm_pkg::blm_form_t form;
  logic [31:0] start_addr;
  logic [31:0] end_addr;
  logic [31:0] wb_addr;

  modport planner (
    input instr, flags, base_value,
    output cond_ok, form, start_addr, end_addr, wb_addr
  );
  modport sequencer (
    output instr, flags, base_value,
    input cond_ok, form, start_addr, end_addr, wb_addr
  );
endinterface : blm_plan_if

// ===== test_block_load_multiple_unit.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end
module test_block_load_multiple_unit;
  logic clk, rst, start, align_check_en, mem_req, mem_rvalid, mem_abort, rf_we, rf_user_bank;
  logic pc_we, status_we, base_we, busy, done, data_abort, align_fault, abort_en;
  logic [3:0] flags, rf_idx, base_reg_field, lat;
  logic [31:0] instr, base_value, saved_status_word, mem_addr, mem_rdata, rf_data;
  logic [31:0] program_counter_reg, current_status_word, base_data, abort_addr;
  int mismatches, checks, pc_n, st_n, bw_n, ab_n, al_n;
  bit hung;
  logic [3:0] fpat, pw;
  logic [36:0] rf_q[$];
  logic [31:0] addr_q[$];
  logic [31:0] pc_v, st_v, bw_v;
  logic [3:0] bf_v;

  blm_block_load blm_block_load_inst (.clk, .rst, .start, .instr, .flags, .base_value,
    .saved_status_word, .align_check_en, .mem_req, .mem_addr, .mem_rvalid, .mem_rdata,
    .mem_abort, .rf_we, .rf_idx, .rf_user_bank, .rf_data, .pc_we, .program_counter_reg,
    .status_we, .current_status_word, .base_we, .base_reg_field, .base_data, .busy, .done,
    .data_abort, .align_fault);

  blm_mem_model blm_mem_model_inst (.clk, .rst, .mem_req, .mem_addr, .lat, .abort_en,
    .abort_addr, .mem_rvalid, .mem_rdata, .mem_abort);

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  // Record every commit pulse with what it carried
  always @(posedge clk) begin
    if (!rst) begin
      if (rf_we === 1'b1) rf_q.push_back({rf_user_bank, rf_idx, rf_data});
      if (mem_req === 1'b1) addr_q.push_back(mem_addr);
      if (pc_we === 1'b1) begin
        pc_n++;
        pc_v = program_counter_reg;
      end
      if (status_we === 1'b1) begin
        st_n++;
        st_v = current_status_word;
      end
      if (base_we === 1'b1) begin
        bw_n++;
        bw_v = base_data;
        bf_v = base_reg_field;
      end
      if (data_abort === 1'b1) ab_n++;
      if (align_fault === 1'b1) al_n++;
    end
  end

  // Same word pattern as the memory model
  function automatic logic [31:0] word_at(input logic [31:0] a);
    return {a[15:0] ^ 16'hc3c3, a[15:0]};
  endfunction : word_at

  // Block-load word; pusw holds the P, U, S and W bits in that order
  function automatic logic [31:0] mk(input logic [3:0] c, input logic [3:0] pusw,
                                     input logic [3:0] rn, input logic [15:0] msk);
    return {c, 3'b100, pusw, 1'b1, rn, msk};
  endfunction : mk

  // Condition codes over N Z C V; code f never passes here
  function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v;
    {n, z, cy, v} = f;
    case (c)
      4'h0: return z;
      4'h1: return !z;
      4'h2: return cy;
      4'h3: return !cy;
      4'h4: return n;
      4'h5: return !n;
      4'h6: return v;
      4'h7: return !v;
      4'h8: return cy && !z;
      4'h9: return !cy || z;
      4'ha: return n == v;
      4'hb: return n != v;
      4'hc: return !z && n == v;
      4'hd: return z || n != v;
      4'he: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : cond_pass

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // Issue one instruction, wait for retire, compare all commits with the model
  task automatic run(input string nm, input logic [31:0] ins, input logic [31:0] b,
                     input logic al, input logic [3:0] fl);
    logic [31:0] a, strt, wbv, pcx;
    logic [36:0] erf[$];
    logic [31:0] ead[$];
    logic ok, afl, xfer, abt, usr, ret;
    int n, k;
    if (hung) return;
    rf_q.delete();
    addr_q.delete();
    pc_n = 0;
    st_n = 0;
    bw_n = 0;
    ab_n = 0;
    al_n = 0;
    @(posedge clk);
    instr <= ins;
    base_value <= b;
    align_check_en <= al;
    flags <= fl;
    saved_status_word <= b ^ ins; // Fresh value so a stale capture shows
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    `CHK("busy taken", 1'b1, busy)
    k = 0;
    while (done !== 1'b1 && k < 300) begin
      @(posedge clk);
      k++;
    end
    if (k >= 300) begin
      // Hung instruction: count it, skip the rest, fall through to the report
      mismatches++;
      hung = 1'b1;
      return;
    end
    @(negedge clk);
    `CHK("busy retired", 1'b0, busy)
    n = $countones(ins[15:0]);
    usr = ins[22] && !ins[15];
    ret = ins[22] && ins[15];
    wbv = ins[23] ? b + 32'(4 * n) : b - 32'(4 * n);
    strt = ins[23] ? b + (ins[24] ? 32'h4 : 32'h0) : wbv + (ins[24] ? 32'h0 : 32'h4);
    ok = cond_pass(ins[31:28], fl) && n > 0;
    afl = ok && al && strt[1:0] != 2'h0;
    xfer = ok && !afl;
    abt = 1'b0;
    a = {strt[31:2], 2'h0};
    for (int i = 0; i < 16; i++) begin
      if (xfer && !abt && ins[i]) begin
        ead.push_back(a);
        abt = abort_en && a == abort_addr;
        if (!abt && i < 15) erf.push_back({usr, 4'(i), word_at(a)});
        pcx = word_at(a);
        a = a + 32'h4;
      end
    end
    `CHK("word count", ead.size(), addr_q.size())
    foreach (ead[j]) `CHK("word address", ead[j], j < addr_q.size() ? addr_q[j] : 'x)
    `CHK("reg write count", erf.size(), rf_q.size())
    foreach (erf[j]) `CHK("reg write", erf[j], j < rf_q.size() ? rf_q[j] : 'x)
    `CHK("pc writes", int'(xfer && !abt && ins[15]), pc_n)
    if (pc_n == 1) `CHK("pc value", pcx, pc_v)
    `CHK("status writes", int'(xfer && !abt && ret), st_n)
    if (st_n == 1) `CHK("status value", saved_status_word, st_v)
    `CHK("base writes", int'(xfer && !abt && !usr && ins[21]), bw_n)
    if (bw_n == 1) `CHK("base value", {ins[19:16], wbv}, {bf_v, bw_v})
    `CHK("aborts", int'(abt), ab_n)
    `CHK("align faults", int'(afl), al_n)
    $display("test %s done", nm);
  endtask : run

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    start = 1'b0;
    instr = 32'h0;
    flags = 4'h0;
    base_value = 32'h0;
    saved_status_word = 32'h2000_0013;
    align_check_en = 1'b0;
    lat = 4'h1;
    abort_en = 1'b0;
    abort_addr = 32'h0;
    mismatches = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Every condition code against two flag patterns
    for (int c = 0; c < 16; c++) begin
      for (int f = 0; f < 2; f++) begin
        fpat = f ? 4'h9 : 4'h6;
        run("cond", mk(4'(c), 4'b0100, 4'h2, 16'h0011), 32'h1000, 1'b0, fpat);
      end
    end
    // All P U W combinations with the PC in the list, fast and slow memory
    for (int v = 0; v < 8; v++) begin
      lat <= v[0] ? 4'h5 : 4'h1;
      pw = {v[2], v[1], 1'b0, v[0]};
      run("variant", mk(4'he, pw, 4'hd, 16'h80a1), 32'h2000, 1'b0, 4'h0);
    end
    // Privileged forms issue as from an exception mode, no banked access after
    run("user bank", mk(4'he, 4'b0110, 4'hd, 16'h7fff), 32'h3000, 1'b0, 4'h0);
    run("user bank db", mk(4'he, 4'b1010, 4'h1, 16'h4002), 32'h3000, 1'b0, 4'h0);
    run("exc return", mk(4'he, 4'b1011, 4'hd, 16'h8003), 32'h3000, 1'b0, 4'h0);
    run("exc return all", mk(4'he, 4'b0110, 4'hd, 16'hffff), 32'h3000, 1'b0, 4'h0);
    run("empty mask", mk(4'he, 4'b0101, 4'h2, 16'h0000), 32'h3000, 1'b0, 4'h0);
    // Abort on the second word of each form
    abort_en <= 1'b1;
    abort_addr <= 32'h2004;
    lat <= 4'h3;
    run("abort wb", mk(4'he, 4'b0101, 4'h3, 16'h8007), 32'h2000, 1'b0, 4'h0);
    run("abort user", mk(4'he, 4'b0110, 4'h2, 16'h0007), 32'h2000, 1'b0, 4'h0);
    run("abort pc", mk(4'he, 4'b0111, 4'h2, 16'h8001), 32'h2000, 1'b0, 4'h0);
    abort_en <= 1'b0;
    // Misaligned base with the check on, then off
    run("align fault", mk(4'he, 4'b0101, 4'h2, 16'h0003), 32'h4002, 1'b1, 4'h0);
    run("unaligned", mk(4'he, 4'b0100, 4'h2, 16'h0003), 32'h4003, 1'b0, 4'h0);
    finish_test();
  end
endmodule : test_block_load_multiple_unit
